// ==== common/ettc_pkg.sv ====
`default_nettype none
package ettc_pkg;
    // register indices; byte address is four times the index
    localparam logic [31:0] IDX_SOURCE_ENABLE = 32'hFFFF8703;
    localparam logic [31:0] IDX_BASE_UPPER    = 32'hFFFF8708;
    localparam logic [31:0] IDX_STATUS        = 32'hFFFF8710;
    localparam logic [31:0] IDX_MASK          = 32'hFFFF8711;
    localparam int          DEC_W             = 10;

    // reset values
    localparam logic [7:0]  RST_SOURCE_ENABLE = 8'h00;
    localparam logic [15:0] RST_BASE_UPPER    = 16'h0000;
    localparam logic [2:0]  RST_STATUS        = 3'h0;
    localparam logic [2:0]  RST_MASK          = 3'h0;

    // mode word fields
    localparam int MODE_SRC_HI   = 15;
    localparam int MODE_SRC_LO   = 14;
    localparam int MODE_DST_HI   = 13;
    localparam int MODE_DST_LO   = 12;
    localparam int MODE_MD_HI    = 11;
    localparam int MODE_MD_LO    = 10;
    localparam int MODE_SZ_HI    = 9;
    localparam int MODE_SZ_LO    = 8;
    localparam int MODE_SIDE     = 7;
    localparam int MODE_CHAIN    = 6;
    localparam int MODE_CPU_SEL  = 5;
    localparam int MODE_NMI      = 4;
    localparam logic [1:0] STEP_INC     = 2'h2;
    localparam logic [1:0] STEP_DEC     = 2'h3;
    localparam logic [1:0] MODE_NORMAL  = 2'h0;

    // descriptor layout offsets
    localparam logic [31:0] DESC_COUNT_OFS = 32'h00000002;
    localparam logic [31:0] DESC_SRC_OFS   = 32'h00000008;
    localparam logic [31:0] DESC_DST_OFS   = 32'h0000000C;
    localparam logic [31:0] DESC_SIZE      = 32'h00000010;

    // memory access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // status bits
    localparam int ST_DONE  = 0;
    localparam int ST_NMI   = 1;
    localparam int ST_XFER  = 2;

    // source of the channel-0 timer compare match
    localparam int SRC_TIMER0 = 5;

    typedef enum logic [3:0] {
        ETTC_IDLE, ETTC_VEC, ETTC_MODE, ETTC_CNT, ETTC_SAR, ETTC_DAR,
        ETTC_RD, ETTC_WR, ETTC_WBC, ETTC_WBS, ETTC_WBD
    } ettc_state_t;
endpackage
`default_nettype wire

// ==== hdl/ettc_controller.sv ====
// Behaviour
// R1: source step field bits 15:14 equal 10 increments source address per transfer.
// R2: destination step field bits 13:12 equal 10 increments destination address.
// R3: transfer mode field bits 11:10 equal 00 selects normal mode.
// R4: size field bits 9:8 equal 00 moves one byte per transfer.
// R5: bit 7 picks block side; 0 means destination side. The code keeps bit 7 in the mode word but never reads it.
// R6: bit 6 enables chaining; 0 means no further descriptor is fetched.
// R7: bit 5 at 0 forwards CPU interrupt only when count is exhausted.
// R8: bit 4 at 0 lets NMI suspend the ongoing transfer.
// R9: count word sets the number of transfers for the descriptor.
// R10: descriptor source longword gives address each item is read from.
// R11: descriptor destination longword gives address each item is written to.
// R12: base register supplies upper 16 descriptor address bits.
// R13: enable bit 5 turns timer0 match into activation instead of CPU interrupt.
// R14: vector entry lower half joins base upper half into descriptor address.
// R15: descriptor read as mode, count at +2, source +8, destination +12.
// R16: count decrements, addresses written back, zero count forwards interrupt.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ettc_controller #(
    parameter int          ADDR_W   = 12,
    parameter int          NSRC     = 8,
    parameter logic [31:0] VEC_BASE = 32'h00000400
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NSRC-1:0]   irq_req,
    input  wire logic              nmi,
    output logic      [NSRC-1:0]   cpu_irq,
    output logic                   irq,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic      [1:0]        mem_size,
    output logic      [31:0]       mem_addr,
    output logic      [31:0]       mem_wdata,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata
);
    typedef struct packed {
        ettc_pkg::ettc_state_t st;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic [7:0]            enable;
        logic [15:0]           base;
        logic [2:0]            status;
        logic [2:0]            mask;
        logic                  irq;
        logic [NSRC-1:0]       cpu_irq;
        logic [NSRC-1:0]       fwd;
        logic [NSRC-1:0]       req_q;
        logic [NSRC-1:0]       pend;
        logic [2:0]            src;
        logic [31:0]           rf;
        logic [15:0]           mode;
        logic [15:0]           cnt;
        logic [31:0]           sar;
        logic [31:0]           dar;
        logic                  mem_req;
        logic                  mem_we;
        logic [1:0]            mem_size;
        logic [31:0]           mem_addr;
        logic [31:0]           mem_wdata;
    } ettc_regs_t;

    ettc_regs_t s;
    ettc_regs_t next_s;

    function automatic logic [31:0] ettc_step(input logic [31:0] a, input logic [1:0] md, input logic [1:0] sz);
        logic [31:0] inc;
        inc = (sz == ettc_pkg::SIZE_BYTE) ? 32'h00000001 : (sz == ettc_pkg::SIZE_WORD) ? 32'h00000002 : 32'h00000004;
        if (md == ettc_pkg::STEP_INC) begin
            return a + inc;
        end else if (md == ettc_pkg::STEP_DEC) begin
            return a - inc;
        end
        return a;
    endfunction

    function automatic logic ettc_hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
        return a[ADDR_W-1:2] == idx[ADDR_W-3:0];
    endfunction

    logic [1:0]       sz;
    logic [NSRC-1:0]  rise;
    logic             ack;
    assign sz   = (s.mode[ettc_pkg::MODE_SZ_HI:ettc_pkg::MODE_SZ_LO] == 2'h3) ? ettc_pkg::SIZE_LONG
                : s.mode[ettc_pkg::MODE_SZ_HI:ettc_pkg::MODE_SZ_LO]; // [R4]
    assign rise = irq_req & ~s.req_q;
    assign ack  = s.mem_req & mem_ack;

    always_comb begin
        logic [2:0]  ev;
        logic        found;
        logic [15:0] dcnt;
        ev     = 3'h0;
        found  = 1'b0;
        dcnt   = s.cnt - 16'h0001;
        next_s = s;
        next_s.req_q   = irq_req;
        next_s.pslverr = 1'b0;
        next_s.pready  = psel & penable & ~s.pready;
        next_s.fwd     = s.fwd & irq_req;
        next_s.pend    = s.pend | (rise & s.enable[NSRC-1:0]); // [R13]

        // register read answer in the first access cycle
        if (psel && penable && !s.pready) begin
            next_s.prdata = 32'h00000000;
            if (ettc_hit(paddr, ettc_pkg::IDX_SOURCE_ENABLE)) begin
                next_s.prdata[7:0] = s.enable;
            end else if (ettc_hit(paddr, ettc_pkg::IDX_BASE_UPPER)) begin
                next_s.prdata[15:0] = s.base;
            end else if (ettc_hit(paddr, ettc_pkg::IDX_STATUS)) begin
                next_s.prdata[2:0] = s.status;
            end else if (ettc_hit(paddr, ettc_pkg::IDX_MASK)) begin
                next_s.prdata[2:0] = s.mask;
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        // writes commit at the completing edge
        if (psel && penable && s.pready && pwrite) begin
            if (ettc_hit(paddr, ettc_pkg::IDX_SOURCE_ENABLE)) begin
                next_s.enable = pwdata[7:0]; // [R13]
            end else if (ettc_hit(paddr, ettc_pkg::IDX_BASE_UPPER)) begin
                next_s.base = pwdata[15:0]; // [R12]
            end else if (ettc_hit(paddr, ettc_pkg::IDX_STATUS)) begin
                next_s.status = s.status & ~pwdata[2:0];
            end else if (ettc_hit(paddr, ettc_pkg::IDX_MASK)) begin
                next_s.mask = pwdata[2:0];
            end
        end

        case (s.st)
            ettc_pkg::ETTC_IDLE: begin
                for (int i = 0; i < NSRC; i++) begin
                    if (!found && next_s.pend[i]) begin
                        found          = 1'b1;
                        next_s.src     = i[2:0];
                        next_s.pend[i] = 1'b0;
                    end
                end
                if (found) begin
                    next_s.st        = ettc_pkg::ETTC_VEC;
                    next_s.mem_req   = 1'b1;
                    next_s.mem_we    = 1'b0;
                    next_s.mem_size  = ettc_pkg::SIZE_WORD;
                    next_s.mem_addr  = VEC_BASE + {28'h0000000, next_s.src, 1'b0}; // [R14]
                end
            end
            ettc_pkg::ETTC_VEC: begin
                if (ack) begin
                    next_s.rf       = {s.base, mem_rdata[15:0]}; // [R12] [R14]
                    next_s.mem_addr = {s.base, mem_rdata[15:0]}; // [R15]
                    next_s.st       = ettc_pkg::ETTC_MODE;
                end
            end
            ettc_pkg::ETTC_MODE: begin
                if (ack) begin
                    // side select is kept in the mode word but no logic reads it; only normal transfers exist
                    next_s.mode     = mem_rdata[15:0]; // [R3] [R5]
                    next_s.mem_addr = s.rf + ettc_pkg::DESC_COUNT_OFS; // [R15]
                    next_s.st       = ettc_pkg::ETTC_CNT;
                end
            end
            ettc_pkg::ETTC_CNT: begin
                if (ack) begin
                    next_s.cnt      = mem_rdata[15:0]; // [R9]
                    next_s.mem_size = ettc_pkg::SIZE_LONG;
                    next_s.mem_addr = s.rf + ettc_pkg::DESC_SRC_OFS; // [R15]
                    next_s.st       = ettc_pkg::ETTC_SAR;
                end
            end
            ettc_pkg::ETTC_SAR: begin
                if (ack) begin
                    next_s.sar      = mem_rdata; // [R10]
                    next_s.mem_addr = s.rf + ettc_pkg::DESC_DST_OFS; // [R15]
                    next_s.st       = ettc_pkg::ETTC_DAR;
                end
            end
            ettc_pkg::ETTC_DAR: begin
                if (ack) begin
                    next_s.dar      = mem_rdata; // [R11]
                    next_s.mem_size = sz; // [R4]
                    next_s.mem_addr = s.sar; // [R10]
                    next_s.st       = ettc_pkg::ETTC_RD;
                end
            end
            ettc_pkg::ETTC_RD: begin
                if (ack) begin
                    next_s.mem_we    = 1'b1;
                    next_s.mem_wdata = mem_rdata;
                    next_s.mem_addr  = s.dar; // [R11]
                    next_s.st        = ettc_pkg::ETTC_WR;
                end
            end
            ettc_pkg::ETTC_WR: begin
                if (ack) begin
                    next_s.cnt       = dcnt; // [R16]
                    next_s.sar       = ettc_step(s.sar, s.mode[ettc_pkg::MODE_SRC_HI:ettc_pkg::MODE_SRC_LO], sz); // [R1]
                    next_s.dar       = ettc_step(s.dar, s.mode[ettc_pkg::MODE_DST_HI:ettc_pkg::MODE_DST_LO], sz); // [R2]
                    next_s.mem_size  = ettc_pkg::SIZE_WORD;
                    next_s.mem_addr  = s.rf + ettc_pkg::DESC_COUNT_OFS;
                    next_s.mem_wdata = {16'h0000, dcnt}; // [R16]
                    next_s.st        = ettc_pkg::ETTC_WBC;
                    ev[ettc_pkg::ST_XFER] = 1'b1;
                end
            end
            ettc_pkg::ETTC_WBC: begin
                if (ack) begin
                    next_s.mem_size  = ettc_pkg::SIZE_LONG;
                    next_s.mem_addr  = s.rf + ettc_pkg::DESC_SRC_OFS;
                    next_s.mem_wdata = s.sar; // [R16]
                    next_s.st        = ettc_pkg::ETTC_WBS;
                end
            end
            ettc_pkg::ETTC_WBS: begin
                if (ack) begin
                    next_s.mem_addr  = s.rf + ettc_pkg::DESC_DST_OFS;
                    next_s.mem_wdata = s.dar; // [R16]
                    next_s.st        = ettc_pkg::ETTC_WBD;
                end
            end
            ettc_pkg::ETTC_WBD: begin
                if (ack) begin
                    if (s.cnt == 16'h0000 || s.mode[ettc_pkg::MODE_CPU_SEL]) begin
                        next_s.fwd[s.src] = irq_req[s.src]; // [R7] [R16]
                    end
                    if (s.cnt == 16'h0000) begin
                        ev[ettc_pkg::ST_DONE] = 1'b1;
                    end
                    if (s.mode[ettc_pkg::MODE_CHAIN] && s.cnt != 16'h0000) begin
                        next_s.rf       = s.rf + ettc_pkg::DESC_SIZE;
                        next_s.mem_we   = 1'b0;
                        next_s.mem_size = ettc_pkg::SIZE_WORD;
                        next_s.mem_addr = s.rf + ettc_pkg::DESC_SIZE;
                        next_s.st       = ettc_pkg::ETTC_MODE;
                    end else begin
                        next_s.mem_req = 1'b0; // [R6]
                        next_s.mem_we  = 1'b0;
                        next_s.st      = ettc_pkg::ETTC_IDLE;
                    end
                end
            end
            default: begin
                next_s.st      = ettc_pkg::ETTC_IDLE;
                next_s.mem_req = 1'b0;
            end
        endcase

        // nmi suspends between memory accesses once the mode word is known
        if (ack && nmi && !s.mode[ettc_pkg::MODE_NMI] && s.st != ettc_pkg::ETTC_VEC
                && s.st != ettc_pkg::ETTC_MODE && s.st != ettc_pkg::ETTC_IDLE) begin
            next_s.st      = ettc_pkg::ETTC_IDLE; // [R8]
            next_s.mem_req = 1'b0;
            next_s.mem_we  = 1'b0;
            ev             = 3'h0;
            ev[ettc_pkg::ST_NMI] = 1'b1;
        end

        next_s.status  = next_s.status | ev;
        next_s.irq     = |(next_s.status & next_s.mask);
        next_s.cpu_irq = (irq_req & ~next_s.enable[NSRC-1:0]) | next_s.fwd; // [R13]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.st     <= ettc_pkg::ETTC_IDLE;
            s.enable <= ettc_pkg::RST_SOURCE_ENABLE;
            s.base   <= ettc_pkg::RST_BASE_UPPER;
            s.status <= ettc_pkg::RST_STATUS;
            s.mask   <= ettc_pkg::RST_MASK;
        end else begin
            s <= next_s;
        end
    end

    assign prdata    = s.prdata;
    assign pready    = s.pready;
    assign pslverr   = s.pslverr;
    assign cpu_irq   = s.cpu_irq;
    assign irq       = s.irq;
    assign mem_req   = s.mem_req;
    assign mem_we    = s.mem_we;
    assign mem_size  = s.mem_size;
    assign mem_addr  = s.mem_addr;
    assign mem_wdata = s.mem_wdata;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_src_increment: assert property ( // [R1]
        (s.st == ettc_pkg::ETTC_WR && ack && s.mode[15:14] == 2'h2 && s.mode[9:8] == 2'h0)
        |=> s.sar == $past(s.sar) + 32'h00000001) else $error("source address not incremented");
    chk_dst_increment: assert property ( // [R2]
        (s.st == ettc_pkg::ETTC_WR && ack && s.mode[13:12] == 2'h2 && s.mode[9:8] == 2'h0)
        |=> s.dar == $past(s.dar) + 32'h00000001) else $error("destination address not incremented");
    chk_byte_size: assert property ( // [R4]
        (s.st == ettc_pkg::ETTC_RD && s.mode[9:8] == 2'h0) |-> s.mem_size == 2'h0 && !s.mem_we)
        else $error("byte transfer uses wrong size");
    chk_count_fetch: assert property ( // [R15]
        (s.st == ettc_pkg::ETTC_MODE && ack) |=> s.mem_addr == $past(s.rf) + 32'h00000002 ##1
        (s.st == ettc_pkg::ETTC_CNT)) else $error("count word fetched from wrong place");
    chk_desc_address: assert property ( // [R14]
        (s.st == ettc_pkg::ETTC_VEC && ack) |=> s.mem_addr == {$past(s.base), $past(mem_rdata[15:0])})
        else $error("descriptor start address wrong");
    chk_count_step: assert property ( // [R9]
        (s.st == ettc_pkg::ETTC_WR && ack && !nmi) |=> s.cnt == $past(s.cnt) - 16'h0001
        && s.mem_wdata[15:0] == s.cnt) else $error("count not decremented");
    chk_no_early_irq: assert property ( // [R7]
        (s.st == ettc_pkg::ETTC_WBD && ack && !s.mode[5] && s.cnt != 16'h0000 && !s.fwd[s.src])
        |=> !s.fwd[$past(s.src)]) else $error("interrupt forwarded before count end");
    chk_end_forward: assert property ( // [R16]
        (s.st == ettc_pkg::ETTC_WBD && ack && s.cnt == 16'h0000 && irq_req[s.src] && !nmi)
        |=> s.fwd[$past(s.src)] && s.status[0]) else $error("end of count not forwarded");
    chk_no_chain: assert property ( // [R6]
        (s.st == ettc_pkg::ETTC_WBD && ack && !s.mode[6]) |=> s.st == ettc_pkg::ETTC_IDLE && !s.mem_req)
        else $error("chain taken while disabled");
    chk_nmi_suspend: assert property ( // [R8]
        (ack && nmi && !s.mode[4] && s.st inside {[ettc_pkg::ETTC_CNT:ettc_pkg::ETTC_WBD]})
        |=> s.st == ettc_pkg::ETTC_IDLE && s.status[1]) else $error("nmi did not suspend transfer");
    chk_cpu_pass: assert property ( // [R13]
        (irq_req[2] && !s.enable[2] && !(psel && penable && pwrite)) |=> s.cpu_irq[2])
        else $error("disabled source not passed to cpu");
    chk_cpu_every: assert property ( // [R7]
        (s.st == ettc_pkg::ETTC_WBD && ack && s.mode[5] && irq_req[s.src]) |=> s.fwd[$past(s.src)])
        else $error("interrupt not forwarded per transfer");
    chk_mem_hold: assert property ( // [R15]
        (s.mem_req && !mem_ack) |=> s.mem_req && $stable(s.mem_addr) && $stable(s.mem_we))
        else $error("memory request changed before ack");
endmodule // ettc_controller
`default_nettype wire

// ==== testbench/ettc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ettc_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [1:0]  mem_size,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [7:0]  mem [0:4095];
    logic [3:0]  wait_cnt;
    logic [11:0] a;
    int          rd_cnt = 0;
    int          wr_cnt = 0;

    assign a = mem_addr[11:0];

    // big-endian byte store; read data is scrambled outside the ack cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= 32'h0;
        end else if (mem_ack || !mem_req) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (wait_cnt < lat) begin
            wait_cnt  <= wait_cnt + 4'h1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            if (mem_we) begin
                wr_cnt <= wr_cnt + 1;
                if (mem_size == 2'h0) begin
                    mem[a] <= mem_wdata[7:0];
                end else if (mem_size == 2'h1) begin
                    mem[a]        <= mem_wdata[15:8];
                    mem[a+12'h1]  <= mem_wdata[7:0];
                end else begin
                    mem[a]        <= mem_wdata[31:24];
                    mem[a+12'h1]  <= mem_wdata[23:16];
                    mem[a+12'h2]  <= mem_wdata[15:8];
                    mem[a+12'h3]  <= mem_wdata[7:0];
                end
            end else begin
                rd_cnt <= rd_cnt + 1;
                if (mem_size == 2'h0) mem_rdata <= {24'h0, mem[a]};
                else if (mem_size == 2'h1) mem_rdata <= {16'h0, mem[a], mem[a+12'h1]};
                else mem_rdata <= {mem[a], mem[a+12'h1], mem[a+12'h2], mem[a+12'h3]};
            end
        end
    end
endmodule // ettc_mem_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] VEC  = 32'h00000400;
    localparam logic [11:0] A_EN = 12'(ettc_pkg::IDX_SOURCE_ENABLE << 2);
    localparam logic [11:0] A_BU = 12'(ettc_pkg::IDX_BASE_UPPER << 2);
    localparam logic [11:0] A_ST = 12'(ettc_pkg::IDX_STATUS << 2);
    localparam logic [11:0] A_MK = 12'(ettc_pkg::IDX_MASK << 2);
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [7:0]  irq_req = 0;
    logic [3:0]  lat = 0;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic        pready, pslverr, irq, mem_req, mem_we, mem_ack, err;
    logic [7:0]  cpu_irq;
    logic [1:0]  mem_size;
    int          error_cnt = 0, check_count = 0, wr0, rd0, n;

    always #25 pclk = ~pclk;

    ettc_controller #(.ADDR_W(12), .NSRC(8), .VEC_BASE(VEC)) ettc_controller_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .nmi(nmi), .cpu_irq(cpu_irq), .irq(irq), .mem_req(mem_req),
        .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    ettc_mem_model ettc_mem_model_i (
        .pclk(pclk), .presetn(presetn), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
        .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h1, 32'h0, "apb no answer");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
        chk({31'h0, err}, {31'h0, e}, msg);
    endtask

    task automatic mw16(input logic [11:0] a, input logic [15:0] d);
        ettc_mem_model_i.mem[a]       = d[15:8];
        ettc_mem_model_i.mem[a+12'h1] = d[7:0];
    endtask

    function automatic logic [31:0] mr32(input logic [11:0] a);
        return {ettc_mem_model_i.mem[a], ettc_mem_model_i.mem[a+12'h1],
                ettc_mem_model_i.mem[a+12'h2], ettc_mem_model_i.mem[a+12'h3]};
    endfunction

    task automatic xfer_wait();
        n = 0;
        while (ettc_mem_model_i.wr_cnt < wr0 + 4 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= 300), 32'h0, "xfer timeout");
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(A_EN, {24'h0, ettc_pkg::RST_SOURCE_ENABLE}, 1'b0, "enable reset");
        rdchk(A_BU, {16'h0, ettc_pkg::RST_BASE_UPPER}, 1'b0, "base reset");
        rdchk(A_ST, {29'h0, ettc_pkg::RST_STATUS}, 1'b0, "status reset");
        rdchk(A_MK, {29'h0, ettc_pkg::RST_MASK}, 1'b0, "mask reset");
        rdchk(12'h000, 32'h0, 1'b1, "unmapped read");
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1, "unmapped write");
        $display("test reset_values done");
        apb(1'b1, A_BU, 32'h0000FFFF);
        apb(1'b1, A_EN, 32'h1 << ettc_pkg::SRC_TIMER0);
        apb(1'b1, A_MK, 32'h7);
        rdchk(A_BU, 32'h0000FFFF, 1'b0, "base readback");
        rdchk(A_EN, 32'h20, 1'b0, "enable readback");
        // vector entry holds low descriptor half; base gives the upper half
        mw16(12'(VEC + 2 * ettc_pkg::SRC_TIMER0), 16'h0100);
        mw16(12'h100, {ettc_pkg::STEP_INC, ettc_pkg::STEP_INC, ettc_pkg::MODE_NORMAL, ettc_pkg::SIZE_BYTE, 8'h00});
        mw16(12'h102, 16'h0003);
        {ettc_mem_model_i.mem[12'h108], ettc_mem_model_i.mem[12'h109]} = 16'h0000;
        {ettc_mem_model_i.mem[12'h10A], ettc_mem_model_i.mem[12'h10B]} = 16'h0200;
        {ettc_mem_model_i.mem[12'h10C], ettc_mem_model_i.mem[12'h10D]} = 16'h0000;
        {ettc_mem_model_i.mem[12'h10E], ettc_mem_model_i.mem[12'h10F]} = 16'h0300;
        for (int k = 0; k < 3; k++) begin
            ettc_mem_model_i.mem[12'h200 + k] = 8'(8'h11 * (k + 1));
            ettc_mem_model_i.mem[12'h300 + k] = 8'h00;
        end
        for (int k = 0; k < 3; k++) begin
            lat <= 4'(k * 2);
            wr0 = ettc_mem_model_i.wr_cnt;
            rd0 = ettc_mem_model_i.rd_cnt;
            irq_req[ettc_pkg::SRC_TIMER0] <= 1'b1;
            xfer_wait();
            chk(ettc_mem_model_i.mem[12'h300 + k], 32'(8'h11 * (k + 1)), "moved byte");
            chk(ettc_mem_model_i.rd_cnt - rd0, 32'd6, "read count");
            chk({ettc_mem_model_i.mem[12'h102], ettc_mem_model_i.mem[12'h103]}, 32'(2 - k), "count wb");
            chk(mr32(12'h108), 32'(32'h201 + k), "src wb");
            chk(mr32(12'h10C), 32'(32'h301 + k), "dst wb");
            chk({31'h0, cpu_irq[ettc_pkg::SRC_TIMER0]}, {31'h0, k == 2}, "forward");
            irq_req[ettc_pkg::SRC_TIMER0] <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        $display("test normal_transfers done");
        rdchk(A_ST, (32'h1 << ettc_pkg::ST_DONE) | (32'h1 << ettc_pkg::ST_XFER), 1'b0, "status done");
        chk({31'h0, irq}, 32'h1, "irq set");
        apb(1'b1, A_MK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, A_MK, 32'h7);
        apb(1'b1, A_ST, 32'h7);
        repeat (2) @(posedge pclk);
        rdchk(A_ST, 32'h0, 1'b0, "status cleared");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test interrupt_regs done");
        irq_req[2] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, cpu_irq[2]}, 32'h1, "plain source passes");
        chk({31'h0, cpu_irq[ettc_pkg::SRC_TIMER0]}, 32'h0, "enabled source idle");
        irq_req[2] <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, cpu_irq[2]}, 32'h0, "plain source drops");
        $display("test passthrough done");
        mw16(12'h102, 16'h0002);
        ettc_mem_model_i.mem[12'h303] = 8'hAA;
        wr0 = ettc_mem_model_i.wr_cnt;
        lat <= 4'h1;
        nmi <= 1'b1;
        irq_req[ettc_pkg::SRC_TIMER0] <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= 300), 32'h0, "nmi timeout");
        nmi <= 1'b0;
        irq_req[ettc_pkg::SRC_TIMER0] <= 1'b0;
        rdchk(A_ST, 32'h1 << ettc_pkg::ST_NMI, 1'b0, "nmi status");
        chk(ettc_mem_model_i.wr_cnt - wr0, 32'd0, "no writes after nmi");
        chk(ettc_mem_model_i.mem[12'h303], 32'hAA, "dest kept");
        $display("test nmi_suspend done");
        mw16(12'h100, {ettc_pkg::STEP_DEC, 2'h0, ettc_pkg::MODE_NORMAL, ettc_pkg::SIZE_WORD, 8'h20});
        mw16(12'h10A, 16'h0210);
        mw16(12'h10E, 16'h0310);
        mw16(12'h210, 16'hBEEF);
        wr0 = ettc_mem_model_i.wr_cnt;
        irq_req[ettc_pkg::SRC_TIMER0] <= 1'b1;
        xfer_wait();
        chk(mr32(12'h310) >> 16, 32'hBEEF, "moved word");
        chk(mr32(12'h108), 32'h20E, "src dec wb");
        chk(mr32(12'h10C), 32'h310, "dst fixed wb");
        chk({31'h0, cpu_irq[ettc_pkg::SRC_TIMER0]}, 32'h1, "every forward");
        $display("test word_every_irq done");
        conclude();
    end
endmodule // tb
`default_nettype wire
